// ===== shared/sbp_pkg.sv
// Package of register map, field layout and reset values for the serial baud and pin block
// What this block does
// - Stop-in-wait set freezes all serial clocks while the controller is in wait mode.
// - Normal pins as master: sample data on MISO, drive data on MOSI.
// - Normal pins as slave: drive data on MISO, sample data on MOSI.
// - Single-wire master ignores MISO; MOSI is input, or output when bidir enable set.
// - Single-wire slave ignores MOSI; MISO is input, or output when bidir enable set.
// - Baud-rate register is readable and writable at any time in any mode.
// - Baud-rate bit 7 is read-only and always reads zero.
// - Prescaler in bits 6..4 divides the bus clock by code plus one.
// - Divisor field divides prescaler output by two to the power code plus one, max 512.
// - Prescaler output feeds the divider; serial clock is bus clock over both divisors.
// - In single-wire mode bidir enable gates the data driver onto the shared pin.
`default_nettype none
package sbp_pkg;
    // Register indices and byte addresses
    localparam logic [3:0]  IDX_CTRL      = 4'h0;
    localparam logic [3:0]  IDX_BAUD      = 4'h2;
    localparam logic [3:0]  IDX_STATUS    = 4'h3;
    localparam logic [3:0]  IDX_DATA      = 4'h5;
    localparam int          ADDR_LSB      = 2;
    // Control register fields
    localparam int          CTRL_SINGLE   = 0;
    localparam int          CTRL_STOPWAIT = 1;
    localparam int          CTRL_BIDIR_OUTPUT_ENABLE  = 3;
    localparam int          CTRL_MASTER   = 4;
    localparam logic [4:0]  CTRL_RESET    = 5'h00;
    // Baud register fields
    localparam int          BAUD_DIV_LSB  = 0;
    localparam int          BAUD_PRE_LSB  = 4;
    localparam logic [6:0]  BAUD_RESET    = 7'h00;
    localparam logic [3:0]  DIV_CODE_MAX  = 4'h8;
    // Status register fields
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_RXFULL   = 1;
    localparam int          STAT_TXREADY  = 2;
    // Transfer shape
    localparam logic [3:0]  BITS_PER_WORD = 4'h8;
    localparam logic [7:0]  SLAVE_IDLE_TX = 8'hFF;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          WORD_WIDTH    = 8;
    // Transfer engine states
    typedef enum logic [0:0] {
        SBP_IDLE = 1'b0,
        SBP_RUN  = 1'b1
    } sbp_state_t;
endpackage
`default_nettype wire

// ===== core/sbp_core.sv
// Serial baud generator, pin configuration, transfer engine, APB slave and transmit FIFO
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none

// Transmit FIFO with valid/ready on both sides
module sbp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0]   count;
    } sbp_fifo_state_t;

    sbp_fifo_state_t             st;
    sbp_fifo_state_t             next_st;
    logic            [WIDTH-1:0] mem [DEPTH];
    logic                        push;
    logic                        pop;

    // Handshakes and honest flags
    assign inReady  = (st.count != (PW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData  = mem[st.rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // Pointer and occupancy update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wrPtr = (st.wrPtr == PW'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = (st.rdPtr == PW'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
        end
        next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wrPtr] <= inData;
        end
    end
endmodule

// Top: APB registers, baud generator, pin steering and shifter
module sbp_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Controller power state
    input  wire logic        waitMode,
    // Serial clock pin
    input  wire logic        sclkIn,
    output logic             sclkOut,
    output logic             sclkOe_n,
    // Master-out pin
    input  wire logic        mosiIn,
    output logic             mosiOut,
    output logic             mosiOe_n,
    // Master-in pin
    input  wire logic        misoIn,
    output logic             misoOut,
    output logic             misoOe_n
);
    typedef struct packed {
        logic [4:0]          ctrl;
        logic [6:0]          baud;
        sbp_pkg::sbp_state_t xfer;
        logic [2:0]          presCnt;
        logic [7:0]          divCnt;
        logic                sclk;
        logic [7:0]          shifter;
        logic                sampleBit;
        logic [3:0]          bitCnt;
        logic [7:0]          rxData;
        logic                rxFull;
        logic                syncA;
        logic                syncB;
        logic                syncC;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                sclkOe_n;
        logic                mosiOut;
        logic                mosiOe_n;
        logic                misoOut;
        logic                misoOe_n;
    } sbp_state_t;

    sbp_state_t  st;
    sbp_state_t  next_st;
    logic [7:0]  txData;
    logic        txValid;
    logic        txPop;
    logic        fifoInReady;
    logic        dataWrite;

    // Decoded fields and bus qualifiers
    logic        isMaster;
    logic        single;
    logic        halted;
    logic [2:0]  preSel;
    logic [3:0]  divSel;
    logic [7:0]  halfLimit;
    logic        rxBit;
    logic [3:0]  regIdx;
    logic        access;
    logic        commit;
    logic        mapped;

    assign isMaster  = st.ctrl[sbp_pkg::CTRL_MASTER];
    assign single    = st.ctrl[sbp_pkg::CTRL_SINGLE];
    assign halted    = st.ctrl[sbp_pkg::CTRL_STOPWAIT] & waitMode;
    assign preSel    = st.baud[sbp_pkg::BAUD_PRE_LSB +: 3];
    assign divSel    = st.baud[sbp_pkg::BAUD_DIV_LSB +: 4];
    assign regIdx    = paddr[sbp_pkg::ADDR_LSB +: 4];
    assign access    = psel & penable;
    assign commit    = access & st.pready;
    assign mapped    = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00)
                       && (regIdx == sbp_pkg::IDX_CTRL || regIdx == sbp_pkg::IDX_BAUD
                       || regIdx == sbp_pkg::IDX_STATUS || regIdx == sbp_pkg::IDX_DATA);
    assign dataWrite = commit & pwrite & mapped & (regIdx == sbp_pkg::IDX_DATA);

    // Half period in prescaled ticks is 2^code; reserved codes clamp to the top
    always_comb begin
        logic [3:0] code;
        logic [8:0] half;
        code      = (divSel > sbp_pkg::DIV_CODE_MAX) ? sbp_pkg::DIV_CODE_MAX : divSel;
        half      = 9'h001 << code;
        halfLimit = 8'(half - 9'h001);
    end

    // Receive pin selection by role and pin mode
    always_comb begin
        if (isMaster) begin
            rxBit = single ? mosiIn : misoIn;
        end else begin
            rxBit = single ? misoIn : mosiIn;
        end
    end

    // Register, baud, shifter and pin next-state logic
    always_comb begin
        logic presTick;
        logic halfTick;
        logic slvRise;
        logic slvFall;
        logic endWord;
        presTick = 1'b0;
        halfTick = 1'b0;
        slvRise  = 1'b0;
        slvFall  = 1'b0;
        endWord  = 1'b0;
        next_st  = st;
        txPop    = 1'b0;

        // Slave clock synchroniser; the first stage feeds only the second
        next_st.syncA = sclkIn;
        next_st.syncB = st.syncA;
        next_st.syncC = st.syncB;

        // Baud chain: prescaler output clocks the divider
        if (!halted && isMaster && st.xfer == sbp_pkg::SBP_RUN) begin
            if (st.presCnt == preSel) begin
                next_st.presCnt = '0;
                presTick        = 1'b1;
            end else begin
                next_st.presCnt = st.presCnt + 3'h1;
            end
            if (presTick) begin
                if (st.divCnt == halfLimit) begin
                    next_st.divCnt = '0;
                    halfTick       = 1'b1;
                end else begin
                    next_st.divCnt = st.divCnt + 8'h01;
                end
            end
        end else if (st.xfer == sbp_pkg::SBP_IDLE) begin
            next_st.presCnt = '0;
            next_st.divCnt  = '0;
        end

        // Slave edges from the external clock, ignored when halted
        if (!isMaster && !halted) begin
            slvRise = st.syncB & ~st.syncC;
            slvFall = ~st.syncB & st.syncC;
        end

        // Transfer engine
        case (st.xfer)
            sbp_pkg::SBP_IDLE: begin
                next_st.bitCnt = '0;
                next_st.sclk   = 1'b0;
                if (!halted && txValid) begin
                    txPop           = 1'b1;
                    next_st.shifter = txData;
                    next_st.xfer    = sbp_pkg::SBP_RUN;
                end else if (!isMaster && slvRise) begin
                    next_st.shifter   = sbp_pkg::SLAVE_IDLE_TX;
                    next_st.sampleBit = rxBit;
                    next_st.xfer      = sbp_pkg::SBP_RUN;
                end
            end
            sbp_pkg::SBP_RUN: begin
                if ((isMaster && halfTick && !st.sclk) || slvRise) begin
                    next_st.sampleBit = rxBit;
                    next_st.sclk      = isMaster;
                end else if ((isMaster && halfTick && st.sclk) || slvFall) begin
                    next_st.sclk    = 1'b0;
                    next_st.shifter = {st.shifter[6:0], st.sampleBit};
                    next_st.bitCnt  = st.bitCnt + 4'h1;
                    endWord         = (st.bitCnt == sbp_pkg::BITS_PER_WORD - 4'h1);
                end
                if (endWord) begin
                    next_st.rxData = {st.shifter[6:0], st.sampleBit};
                    next_st.rxFull = 1'b1;
                    next_st.xfer   = sbp_pkg::SBP_IDLE;
                end
            end
            default: begin
                next_st.xfer = sbp_pkg::SBP_IDLE;
            end
        endcase

        // APB answer one cycle into access; data writes wait for FIFO room
        next_st.pready  = access & ~st.pready & ~(pwrite & mapped
                          & (regIdx == sbp_pkg::IDX_DATA) & ~fifoInReady);
        next_st.pslverr = next_st.pready & ~mapped;
        if (next_st.pready && !pwrite) begin
            case (regIdx)
                sbp_pkg::IDX_CTRL: begin
                    next_st.prdata = {27'h000_0000, st.ctrl};
                end
                sbp_pkg::IDX_BAUD: begin
                    next_st.prdata = {24'h00_0000, 1'b0, st.baud};
                end
                sbp_pkg::IDX_STATUS: begin
                    next_st.prdata = {29'h0000_0000, fifoInReady, st.rxFull,
                                      st.xfer == sbp_pkg::SBP_RUN};
                end
                sbp_pkg::IDX_DATA: begin
                    next_st.prdata = {24'h00_0000, st.rxData};
                end
                default: begin
                    next_st.prdata = '0;
                end
            endcase
            if (!mapped) begin
                next_st.prdata = '0;
            end
        end else if (next_st.pready) begin
            next_st.prdata = '0;
        end

        // Register writes take effect on the completing edge
        if (commit && mapped) begin
            if (pwrite && regIdx == sbp_pkg::IDX_CTRL) begin
                next_st.ctrl = pwdata[4:0];
            end
            if (pwrite && regIdx == sbp_pkg::IDX_BAUD) begin
                next_st.baud = pwdata[6:0];
            end
            if (!pwrite && regIdx == sbp_pkg::IDX_DATA && !endWord) begin
                next_st.rxFull = 1'b0; // Completion wins over the read clear
            end
        end

        // Pin drivers; enables are low while driving
        next_st.sclkOe_n = ~next_st.ctrl[sbp_pkg::CTRL_MASTER];
        next_st.mosiOut  = next_st.shifter[7];
        next_st.misoOut  = next_st.shifter[7];
        if (next_st.ctrl[sbp_pkg::CTRL_MASTER]) begin
            next_st.misoOe_n = 1'b1;
            next_st.mosiOe_n = next_st.ctrl[sbp_pkg::CTRL_SINGLE]
                               & ~next_st.ctrl[sbp_pkg::CTRL_BIDIR_OUTPUT_ENABLE];
        end else begin
            next_st.mosiOe_n = 1'b1;
            next_st.misoOe_n = next_st.ctrl[sbp_pkg::CTRL_SINGLE]
                               & ~next_st.ctrl[sbp_pkg::CTRL_BIDIR_OUTPUT_ENABLE];
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st          <= '0;
            st.ctrl     <= sbp_pkg::CTRL_RESET;
            st.baud     <= sbp_pkg::BAUD_RESET;
            st.xfer     <= sbp_pkg::SBP_IDLE;
            st.sclkOe_n <= 1'b1;
            st.mosiOe_n <= 1'b1;
            st.misoOe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Transmit FIFO between the data register and the shifter
    sbp_fifo #(
        .WIDTH (sbp_pkg::WORD_WIDTH),
        .DEPTH (sbp_pkg::FIFO_DEPTH)
    ) u_txFifo (
        .clk      (clk),
        .nrst     (nrst),
        .inData   (pwdata[7:0]),
        .inValid  (dataWrite),
        .inReady  (fifoInReady),
        .outData  (txData),
        .outValid (txValid),
        .outReady (txPop)
    );

    // Outputs straight from the state register
    assign prdata   = st.prdata;
    assign pready   = st.pready;
    assign pslverr  = st.pslverr;
    assign sclkOut  = st.sclk;
    assign sclkOe_n = st.sclkOe_n;
    assign mosiOut  = st.mosiOut;
    assign mosiOe_n = st.mosiOe_n;
    assign misoOut  = st.misoOut;
    assign misoOe_n = st.misoOe_n;
endmodule
`default_nettype wire

// ===== dv/sbp_chk_pkgless_chk.sv
// Checker for pin steering, serial clock rate, wait halt and baud register reads
`default_nettype none
module sbp_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Power state and pins
    input wire logic        waitMode,
    input wire logic        sclkOut,
    input wire logic        sclkOe_n,
    input wire logic        mosiOe_n,
    input wire logic        misoOe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ctrl;
    logic [6:0] baud;
    logic [1:0] age;
    int         hiCnt;
    int         half;
    logic       ok;
    logic       wrEnd;
    // Shadow settings; ok once the pin setup has had time to settle
    assign wrEnd = psel && penable && pready && pwrite;
    assign ok    = age == 2'h3;
    assign half  = (int'(baud[6:4]) + 1) << ((baud[3:0] > 4'h8) ? 8 : int'(baud[3:0]));
    // Shadow registers and serial clock high time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl  <= 5'h00;
            baud  <= 7'h00;
            age   <= 2'h0;
            hiCnt <= 0;
        end else begin
            if (wrEnd && paddr == 8'h00) ctrl <= pwdata[4:0];
            if (wrEnd && paddr == 8'h08) baud <= pwdata[6:0];
            age   <= (wrEnd && paddr == 8'h00) ? 2'h0 : (ok ? age : age + 2'h1);
            hiCnt <= sclkOut ? hiCnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_PIN_MST: assert property (ok && ctrl[4] && !ctrl[0] |-> !mosiOe_n && misoOe_n)
        else $error("master pin steering wrong");
    AST_PIN_SLV: assert property (ok && !ctrl[4] && !ctrl[0] |-> !misoOe_n && mosiOe_n)
        else $error("slave pin steering wrong");
    AST_ONE_MST: assert property (ok && ctrl[4] && ctrl[0]
        |-> misoOe_n && mosiOe_n == !ctrl[3])
        else $error("single wire master steering wrong");
    AST_ONE_SLV: assert property (ok && !ctrl[4] && ctrl[0]
        |-> mosiOe_n && misoOe_n == !ctrl[3])
        else $error("single wire slave steering wrong");
    AST_CLK_SLV: assert property (ok && !ctrl[4] |-> sclkOe_n && !sclkOut)
        else $error("slave drives serial clock");
    AST_CLK_MST: assert property (ok && ctrl[4] |-> !sclkOe_n)
        else $error("master does not drive serial clock");
    AST_WAIT_HALT: assert property ((ctrl[1] && waitMode)[*3] |-> $stable(sclkOut))
        else $error("serial clock ran in wait");
    AST_HALF_TIME: assert property ($fell(sclkOut) && !ctrl[1] |-> hiCnt == half)
        else $error("serial clock high time wrong");
    AST_BAUD_READ: assert property (pready && !pwrite && psel && paddr == 8'h08
        |-> prdata == {25'h000_0000, baud})
        else $error("baud read value wrong");
    AST_BAUD_ANY: assert property (psel && penable && !pready && paddr == 8'h08
        |=> pready && !pslverr)
        else $error("baud access refused");
    // Main scenarios reached
    COV_RATE: cover property ($fell(sclkOut) && !ctrl[1]);
    COV_HALT: cover property ((ctrl[1] && waitMode)[*3]);
    COV_ONE_IN: cover property (ok && ctrl[0] && !ctrl[3]);
endmodule
bind sbp_core sbp_chk sbp_chk_i (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .waitMode(waitMode), .sclkOut(sclkOut), .sclkOe_n(sclkOe_n), .mosiOe_n(mosiOe_n),
    .misoOe_n(misoOe_n)
);
`default_nettype wire

// ===== dv/sbp_peer.sv
// Far-side serial device: slave on the block's clock, or master clocking the block
`default_nettype none
module sbp_peer (
    // Clock and role
    input  wire logic       clk,
    input  wire logic       actMaster,
    // Frame control
    input  wire logic       go,
    input  wire logic [7:0] txByte,
    output logic            done,
    output logic [7:0]      rxByte,
    // Pins
    input  wire logic       sclkPin,
    input  wire logic       dinPin,
    output logic            sclkDrv,
    output logic            doutDrv
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 8;
    logic [7:0] sh;
    initial begin
        {sclkDrv, sh, rxByte} = '0;
        done = 1'b1;
    end
    // MSB sits on the line before the first rise; clock idles low between frames
    always @(posedge go) begin
        sh = txByte;
        done = 1'b0;
        if (actMaster) begin
            repeat (8) begin
                repeat (HALF) @(posedge clk);
                sclkDrv <= 1'b1;
                repeat (HALF) @(posedge clk);
                sclkDrv <= 1'b0;
            end
            repeat (HALF) @(posedge clk);
        end
        done = 1'b1;
    end
    // Sample on rise, shift on fall; spent bits toggle so a stale line never matches
    always @(posedge sclkPin) rxByte <= {rxByte[6:0], dinPin};
    always @(negedge sclkPin) sh <= {sh[6:0], ~sh[0]};
    assign doutDrv = sh[7];
endmodule
`default_nettype wire

// ===== dv/tb_spi_baud_and_pin_config.sv
// Self-checking bench for the serial baud and pin block
`default_nettype none
module tb_spi_baud_and_pin_config;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [4:0] c; logic [7:0] b, rb; int half; } sbp_row_t;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, waitMode, go, rerr, seen;
    logic        sclkOut, sclkOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n;
    logic        peerSclk, peerDout, peerDone, sclkW, mosiW, misoW;
    logic [4:0]  ctrl;
    logic [7:0]  paddr, pByte, peerRx, dutB;
    logic [31:0] pwdata, prdata, rdata;
    int          failures, comparisons, hiTot, hiBase, cycles;
    // Control, baud written, baud read back, expected half period
    sbp_row_t rows [8] = '{
        '{5'h10, 8'h80, 8'h00, 1}, '{5'h19, 8'h71, 8'h71, 16}, '{5'h11, 8'hA3, 8'h23, 24},
        '{5'h10, 8'h18, 8'h18, 512}, '{5'h10, 8'h0A, 8'h0A, 256}, '{5'h00, 8'hF0, 8'h70, 0},
        '{5'h09, 8'h3C, 8'h3C, 0}, '{5'h01, 8'h00, 8'h00, 0}};
    // Pin levels from all drivers; undriven lines are pulled up
    assign sclkW = !sclkOe_n ? sclkOut : peerSclk;
    assign mosiW = !mosiOe_n ? mosiOut : (ctrl[4] == ctrl[0] ? peerDout : 1'b1);
    assign misoW = !misoOe_n ? misoOut : (ctrl[4] != ctrl[0] ? peerDout : 1'b1);
    sbp_core sbp_core_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .waitMode(waitMode), .sclkIn(sclkW), .sclkOut(sclkOut),
        .sclkOe_n(sclkOe_n), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe_n(mosiOe_n),
        .misoIn(misoW), .misoOut(misoOut), .misoOe_n(misoOe_n));
    sbp_peer sbp_peer_i (.clk(clk), .actMaster(!ctrl[4]), .go(go), .txByte(pByte),
        .done(peerDone), .rxByte(peerRx), .sclkPin(sclkW), .dinPin(ctrl[4] ? mosiW : misoW),
        .sclkDrv(peerSclk), .doutDrv(peerDout));
    // Clock, serial high time and hang limit
    always #2 clk = ~clk;
    always @(posedge clk) begin
        hiTot += (sclkOut === 1'b1) ? 1 : 0;
        if (++cycles == 60000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0000_0000);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse_go(input logic [7:0] b);
        pByte <= b;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {clk, nrst, psel, penable, pwrite, waitMode, go, paddr, pByte, ctrl, pwdata} = '0;
        {failures, comparisons, hiTot, cycles} = '0;
        repeat (3) @(posedge clk);
        chk(32'({sclkOe_n, mosiOe_n, misoOe_n}), 32'h0000_0007);
        nrst <= 1'b1;
        apb(1'b0, 8'h08);
        chk(rdata, 32'h0000_0000);
        apb(1'b0, 8'h04);
        chk(32'(rerr), 32'h0000_0001);
        // Clocks keep running in wait while stop-in-wait is clear
        waitMode <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            dutB = 8'hA5 + 8'(i);
            ctrl <= rows[i].c;
            apb(1'b1, 8'h00, 32'(rows[i].c));
            apb(1'b1, 8'h08, 32'(rows[i].b));
            apb(1'b0, 8'h08);
            chk(rdata, 32'(rows[i].rb));
            hiBase = hiTot;
            if (rows[i].c[4]) begin
                pulse_go(8'h5A - 8'(i));
                apb(1'b1, 8'h14, 32'(dutB));
                do apb(1'b0, 8'h0C); while (rdata[0] !== 1'b0);
            end else begin
                apb(1'b1, 8'h14, 32'(dutB));
                pulse_go(8'h5A - 8'(i));
                do @(posedge clk); while (peerDone !== 1'b1);
            end
            chk(32'(hiTot - hiBase), 32'(8 * rows[i].half));
            if (!rows[i].c[0] || rows[i].c[3]) chk(32'(peerRx), 32'(dutB));
            apb(1'b0, 8'h14);
            if (!rows[i].c[0] || !rows[i].c[3]) chk(rdata[7:0], 8'h5A - 8'(i));
        end
        // Stop-in-wait freezes a frame mid-way; the baud register stays reachable
        waitMode <= 1'b0;
        ctrl <= 5'h12;
        apb(1'b1, 8'h00, 32'h0000_0012);
        apb(1'b1, 8'h08, 32'h0000_0005);
        pulse_go(8'h81);
        apb(1'b1, 8'h14, 32'h0000_0066);
        repeat (40) @(posedge clk);
        waitMode <= 1'b1;
        repeat (3) @(posedge clk);
        seen = sclkOut;
        apb(1'b0, 8'h08);
        chk(rdata, 32'h0000_0005);
        repeat (100) @(posedge clk);
        chk(32'(sclkOut), 32'(seen));
        waitMode <= 1'b0;
        do apb(1'b0, 8'h0C); while (rdata[0] !== 1'b0);
        chk(32'(peerRx), 32'h0000_0066);
        apb(1'b0, 8'h14);
        chk(rdata[7:0], 8'h81);
        // Reset after the last frame frees the pins and clears the settings
        nrst <= 1'b0;
        ctrl <= 5'h00;
        @(posedge clk);
        chk(32'({sclkOe_n, mosiOe_n, misoOe_n}), 32'h0000_0007);
        nrst <= 1'b1;
        apb(1'b0, 8'h08);
        chk(rdata, 32'h0000_0000);
        chk(32'(sclkOe_n), 32'h0000_0001);
        tally_and_finish();
    end
endmodule
`default_nettype wire
